/* rtl/std_timer_pkg.sv */
// constants, field layouts and types for the 16-bit standard timer
// assumes a 32-bit avalon-mm register slave with word-aligned registers
package std_timer_pkg;
	// register byte addresses (one aligned word each)
	localparam logic [4:0] ADDR_CTRL0 = 5'h00;
	localparam logic [4:0] ADDR_CTRL1 = 5'h04;
	localparam logic [4:0] ADDR_CNT_LO = 5'h08;
	localparam logic [4:0] ADDR_CNT_HI = 5'h0c;
	localparam logic [4:0] ADDR_CMPA_LO = 5'h10;
	localparam logic [4:0] ADDR_CMPA_HI = 5'h14;
	localparam logic [4:0] ADDR_PERIOD = 5'h18;
	localparam logic [4:0] ADDR_FLAGS = 5'h1c;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [7:0] P_ZERO = 8'h00;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
	// prescaler divide counts (terminal values)
	localparam logic [5:0] DIV4_MASK = 6'h03;
	localparam logic [5:0] DIV16_MASK = 6'h0f;
	localparam logic [5:0] DIV64_MASK = 6'h3f;
	localparam logic [5:0] PRE_ZERO = 6'h00;
	// control register zero: pause, clock select, on/off; bits 2..0 read zero
	typedef struct packed {
		logic counter_pause;
		logic [2:0] counter_clock_select;
		logic timer_on_off;
		logic [2:0] unused;
	} ctrl0_t;
	typedef enum logic [1:0] {
		MODE_COMPARE, MODE_CAPTURE, MODE_PWM, MODE_TIMER
	} op_mode_t;
	// control register one
	typedef struct packed {
		op_mode_t operating_mode;
		logic [1:0] output_function;
		logic output_initial_level;
		logic output_invert;
		logic pwm_role_swap;
		logic clear_source_select;
	} ctrl1_t;
	localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_FH_DIV16 = 3'h2;
	localparam logic [2:0] CK_FH_DIV64 = 3'h3;
	localparam logic [2:0] CK_TBC = 3'h4;
	localparam logic [2:0] CK_NONE = 3'h5;
	localparam logic [2:0] CK_PIN_RISE = 3'h6;
	localparam logic [2:0] CK_PIN_FALL = 3'h7;
	localparam logic [1:0] IO_00 = 2'h0;
	localparam logic [1:0] IO_01 = 2'h1;
	localparam logic [1:0] IO_10 = 2'h2;
	localparam logic [1:0] IO_11 = 2'h3;
	// flags register bit positions
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_P_BIT = 1;
	// pin outputs carried together
	typedef struct packed {
		logic level;
		logic enable;
	} pin_out_t;
endpackage

/* rtl/edge_sync.sv */
// two-flop synchroniser with rise and fall detection on the synchronised level
// assumes the input is asynchronous to i_mclk
`timescale 1ns/10ps
module edge_sync (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);
	logic meta;
	logic sync;
	logic last;

	// the first flop feeds only the second one
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= i_async;
			sync <= meta;
			last <= sync;
		end
	end

	assign o_level = sync;
	assign o_rise = sync & ~last;
	assign o_fall = ~sync & last;
endmodule

/* rtl/std_timer.sv */
// 16-bit standard timer: counter, comparators a and p, output and capture logic
// assumes avalon-mm master with waitrequest on i_mclk; fh and time base are pulses
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module std_timer
	import std_timer_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic i_fh_tick,
	input wire logic i_time_base_clock,
	input wire logic i_external_count_pin,
	input wire logic i_timer_pin_zero,
	input wire logic i_timer_pin_one,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output pin_out_t o_timer_pin_zero,
	output pin_out_t o_timer_pin_one,
	output logic o_match_a_flag,
	output logic o_match_p_flag
);
	ctrl0_t ctrl0;
	ctrl1_t ctrl1;
	logic [15:0] count;
	logic [15:0] compare_a_value;
	logic [7:0] period_compare_value;
	logic [5:0] sys_pre;
	logic [5:0] fh_pre;
	logic on_last;
	logic out_state;
	logic ack;
	logic ext_rise;
	logic ext_fall;
	logic p0_rise;
	logic p0_fall;
	logic p1_rise;
	logic p1_fall;

	// pin edges are synchronised before any use
	edge_sync u_sync_ext (
		.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_async(i_external_count_pin),
		.o_level(), .o_rise(ext_rise), .o_fall(ext_fall)
	);
	edge_sync u_sync_p0 (
		.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_async(i_timer_pin_zero),
		.o_level(), .o_rise(p0_rise), .o_fall(p0_fall)
	);
	edge_sync u_sync_p1 (
		.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_async(i_timer_pin_one),
		.o_level(), .o_rise(p1_rise), .o_fall(p1_fall)
	);

	// decode helpers
	function automatic logic byte_hit(input logic [4:0] a, input logic [4:0] r);
		byte_hit = (a == r);
	endfunction

	// bus decode: one wait cycle, then answer on the ack cycle
	wire bus_req = (i_avs_read | i_avs_write) & ~ack;
	wire wr_go = i_avs_write & ack;
	wire wr_lane0 = wr_go & i_avs_byteenable[0];
	wire wr_ctrl0 = wr_lane0 & byte_hit(i_avs_address, ADDR_CTRL0);
	wire wr_ctrl1 = wr_lane0 & byte_hit(i_avs_address, ADDR_CTRL1);
	wire wr_a_lo = wr_lane0 & byte_hit(i_avs_address, ADDR_CMPA_LO);
	wire wr_a_hi = wr_lane0 & byte_hit(i_avs_address, ADDR_CMPA_HI);
	wire wr_period = wr_lane0 & byte_hit(i_avs_address, ADDR_PERIOD);
	wire wr_flags = wr_lane0 & byte_hit(i_avs_address, ADDR_FLAGS);
	wire [7:0] wdata = i_avs_writedata[7:0];
	wire [7:0] ctrl0_wr = {wdata[7:3], 3'h0};

	// prescale enables; fh is the high-speed clock given as a tick on i_mclk
	wire sys4_tick = (sys_pre[1:0] == DIV4_MASK[1:0]);
	wire fh16_tick = i_fh_tick & ((fh_pre & DIV16_MASK) == DIV16_MASK);
	wire fh64_tick = i_fh_tick & (fh_pre == DIV64_MASK);

	// clock source select; code 101 leaves no clock
	wire [2:0] cks = ctrl0.counter_clock_select;
	wire src_tick = (cks == CK_SYS_DIV4) ? sys4_tick :
		(cks == CK_SYS) ? 1'b1 :
		(cks == CK_FH_DIV16) ? fh16_tick :
		(cks == CK_FH_DIV64) ? fh64_tick :
		(cks == CK_TBC) ? i_time_base_clock :
		(cks == CK_PIN_RISE) ? ext_rise :
		(cks == CK_PIN_FALL) ? ext_fall : 1'b0;
	// on low or pause held means no tick: the count simply stays
	wire tick = src_tick & ctrl0.timer_on_off & ~ctrl0.counter_pause;
	wire on_rise = ctrl0.timer_on_off & ~on_last;

	// comparators: p sees only the top byte, a the whole count
	wire mode_pwm = (ctrl1.operating_mode == MODE_PWM);
	wire mode_cmp = (ctrl1.operating_mode == MODE_COMPARE);
	wire mode_cap = (ctrl1.operating_mode == MODE_CAPTURE);
	wire mode_tmr = (ctrl1.operating_mode == MODE_TIMER);
	wire [15:0] count_inc = count + CNT_ONE;
	wire hit_a = tick & (count_inc == compare_a_value);
	wire p_zero = (period_compare_value == P_ZERO);
	wire hit_p = tick & ~p_zero & (count_inc[15:8] == period_compare_value) &
		(count_inc[7:0] == RESET_BYTE);
	wire ovf = tick & (count == CNT_MAX);
	// period with p at zero is the full overflow, otherwise 256*n
	wire p_end = hit_p | (ovf & p_zero);

	// clear source: pwm picks by role swap, capture free-runs, else clear select
	wire clr_a = mode_pwm ? ctrl1.pwm_role_swap :
		mode_cap ? 1'b0 : ctrl1.clear_source_select;
	wire clr_p = mode_pwm ? ~ctrl1.pwm_role_swap :
		mode_cap ? 1'b0 : ~ctrl1.clear_source_select;
	wire auto_clr = (clr_a & hit_a) | (clr_p & p_end) | ovf;

	// capture edge select; 11 disables capture
	wire cap_rise = p0_rise | p1_rise;
	wire cap_fall = p0_fall | p1_fall;
	wire cap_edge = (ctrl1.output_function == IO_00) ? cap_rise :
		(ctrl1.output_function == IO_01) ? cap_fall :
		(ctrl1.output_function == IO_10) ? (cap_rise | cap_fall) : 1'b0;
	wire cap_go = mode_cap & ctrl0.timer_on_off & cap_edge;

	// flag events; p flag suppressed with clear select 1 outside pwm
	wire set_a = mode_cap ? cap_go : hit_a;
	wire set_p = (mode_pwm | ~ctrl1.clear_source_select) & ~mode_cap & p_end;

	// pwm duty and period; duty from p is its 256 multiple or the full count
	wire [16:0] p_span = p_zero ? 17'h10000 : {1'b0, period_compare_value, RESET_BYTE};
	wire [16:0] a_span = {1'b0, compare_a_value};
	wire [16:0] duty = ctrl1.pwm_role_swap ? p_span : a_span;
	wire [16:0] period = ctrl1.pwm_role_swap ? a_span : p_span;
	// duty at or above period keeps the active level throughout
	wire pwm_active = (duty >= period) | ({1'b0, count} < duty);

	// compare mode action on match a; equal to the current level shows nothing
	wire cmp_next = (ctrl1.output_function == IO_01) ? 1'b0 :
		(ctrl1.output_function == IO_10) ? 1'b1 :
		(ctrl1.output_function == IO_11) ? ~out_state : out_state;

	// pwm and single pulse levels relative to the active level
	wire act = ctrl1.output_initial_level;
	wire pwm_level = (ctrl1.output_function == IO_00) ? ~act :
		(ctrl1.output_function == IO_01) ? act :
		(ctrl1.output_function == IO_10) ? (pwm_active ? act : ~act) :
		out_state;
	wire pulse_mode = mode_pwm & (ctrl1.output_function == IO_11);

	// next output state; compare mode re-arms to initial level on on-bit rise
	wire next_out = (mode_cmp & on_rise) ? ctrl1.output_initial_level :
		(mode_cmp & hit_a) ? cmp_next :
		(pulse_mode & on_rise) ? act :
		(pulse_mode & (hit_a | ~ctrl0.timer_on_off)) ? ~act :
		(mode_pwm & ~pulse_mode) ? pwm_level : out_state;
	// polarity inverts the pin in every mode; pin not driven in timer or capture mode
	wire pin_level = out_state ^ ctrl1.output_invert;
	wire pin_en = ~mode_tmr & ~mode_cap;

	// next count: software only clears to zero on on-bit rise
	wire [15:0] next_count = on_rise ? CNT_ZERO :
		(tick & auto_clr) ? CNT_ZERO :
		tick ? count_inc : count;

	// read mux; control bits 2..0 of control zero read zero
	wire [7:0] rd_byte = byte_hit(i_avs_address, ADDR_CTRL0) ? ctrl0 :
		byte_hit(i_avs_address, ADDR_CTRL1) ? ctrl1 :
		byte_hit(i_avs_address, ADDR_CNT_LO) ? count[7:0] :
		byte_hit(i_avs_address, ADDR_CNT_HI) ? count[15:8] :
		byte_hit(i_avs_address, ADDR_CMPA_LO) ? compare_a_value[7:0] :
		byte_hit(i_avs_address, ADDR_CMPA_HI) ? compare_a_value[15:8] :
		byte_hit(i_avs_address, ADDR_PERIOD) ? period_compare_value :
		byte_hit(i_avs_address, ADDR_FLAGS) ? {6'h00, o_match_p_flag, o_match_a_flag} :
		UNMAPPED_READ[7:0];

	// bus slave handshake
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack <= 1'b0;
			o_avs_readdata <= UNMAPPED_READ;
		end else begin
			ack <= bus_req;
			o_avs_readdata <= {24'h000000, rd_byte};
		end
	end
	// waitrequest stays high except on the ack cycle
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= ~bus_req;
		end
	end

	// control registers; changing mode while on is left to software
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl0 <= ctrl0_t'(RESET_BYTE);
			ctrl1 <= ctrl1_t'(RESET_BYTE);
			period_compare_value <= RESET_BYTE;
		end else begin
			if (wr_ctrl0) begin
				ctrl0 <= ctrl0_t'(ctrl0_wr);
			end
			if (wr_ctrl1) begin
				ctrl1 <= ctrl1_t'(wdata);
			end
			if (wr_period) begin
				period_compare_value <= wdata;
			end
		end
	end

	// compare a pair; a capture wins over a software write in the same cycle
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			compare_a_value <= CNT_ZERO;
		end else if (cap_go) begin
			compare_a_value <= count;
		end else begin
			if (wr_a_lo) begin
				compare_a_value[7:0] <= wdata;
			end
			if (wr_a_hi) begin
				compare_a_value[15:8] <= wdata;
			end
		end
	end

	// counter, prescalers and on-bit history
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count <= CNT_ZERO;
			sys_pre <= PRE_ZERO;
			fh_pre <= PRE_ZERO;
			on_last <= 1'b0;
		end else begin
			count <= next_count;
			sys_pre <= sys_pre + 6'h01;
			fh_pre <= i_fh_tick ? fh_pre + 6'h01 : fh_pre;
			on_last <= ctrl0.timer_on_off;
		end
	end

	// sticky flags: a hardware set wins over a write-one clear
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_match_a_flag <= 1'b0;
			o_match_p_flag <= 1'b0;
		end else begin
			o_match_a_flag <= set_a | (o_match_a_flag & ~(wr_flags & wdata[FLAG_A_BIT]));
			o_match_p_flag <= set_p | (o_match_p_flag & ~(wr_flags & wdata[FLAG_P_BIT]));
		end
	end

	// output state and registered pins
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			out_state <= 1'b0;
			o_timer_pin_zero <= '0;
			o_timer_pin_one <= '0;
		end else begin
			out_state <= next_out;
			o_timer_pin_zero <= '{level: pin_level, enable: pin_en};
			o_timer_pin_one <= '{level: pin_level, enable: pin_en};
		end
	end
endmodule

/* test/std_timer_asserts.sv */
// concurrent checks on the standard timer ports
// assumes binding to std_timer; register mirrors follow bus writes as they land
`timescale 1ns/10ps
module std_timer_asserts
	import std_timer_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire pin_out_t o_timer_pin_zero,
	input wire logic o_match_a_flag,
	input wire logic o_match_p_flag
);
	logic lands;
	logic clr_a;
	logic hold_low;
	logic ign_p;
	ctrl0_t c0;
	ctrl1_t c1;
	logic [2:0] held;
	logic [2:0] off_cnt;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	// decode of landing writes and of the modes the checks care about
	assign lands = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	assign clr_a = lands && i_avs_address == ADDR_FLAGS && i_avs_writedata[FLAG_A_BIT];
	assign hold_low = c1.operating_mode == MODE_COMPARE && c1.output_function == IO_01
		&& !c1.output_initial_level && c0.timer_on_off;
	assign ign_p = c1.clear_source_select && c1.operating_mode inside {MODE_COMPARE, MODE_TIMER};
	// mirrors plus saturating run lengths; counters avoid long repetitions
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			c0 <= '0;
			c1 <= '0;
			held <= '0;
			off_cnt <= '0;
		end else begin
			if (lands && i_avs_address == ADDR_CTRL0) c0 <= ctrl0_t'(i_avs_writedata[7:0]);
			if (lands && i_avs_address == ADDR_CTRL1) c1 <= ctrl1_t'(i_avs_writedata[7:0]);
			held <= !hold_low ? 3'h0 : (held == 3'h7 ? held : held + 3'h1);
			off_cnt <= c0.timer_on_off ? 3'h0 : (off_cnt == 3'h7 ? off_cnt : off_cnt + 3'h1);
		end
	end
	sequence s_req;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	sequence s_ack;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence
	sequence s_on_rise;
		lands && i_avs_address == ADDR_CTRL0 && i_avs_writedata[3] && !c0.timer_on_off
			&& c1.operating_mode == MODE_COMPARE;
	endsequence
	property p_ack;
		s_req |=> s_ack;
	endproperty
	property p_rd_upper;
		!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000;
	endproperty
	property p_on_init;
		s_on_rise |-> ##[1:3] o_timer_pin_zero.level == (c1.output_initial_level ^ c1.output_invert);
	endproperty
	property p_timer_undriven;
		c1.operating_mode == MODE_TIMER && $past(c1.operating_mode) == MODE_TIMER
			|-> !o_timer_pin_zero.enable;
	endproperty
	property p_cmp_driven;
		c0.timer_on_off && $past(c0.timer_on_off) && c1.operating_mode == MODE_COMPARE
			&& $past(c1.operating_mode) == MODE_COMPARE |-> o_timer_pin_zero.enable;
	endproperty
	property p_no_pflag;
		$rose(o_match_p_flag) |-> !(ign_p && $past(ign_p));
	endproperty
	property p_flag_sticky;
		$fell(o_match_a_flag) |-> $past(clr_a) || $past(clr_a, 2);
	endproperty
	property p_off_quiet;
		off_cnt == 3'h7 && c1.operating_mode != MODE_CAPTURE |-> !$rose(o_match_a_flag);
	endproperty
	property p_same_level;
		held == 3'h7 |-> $stable(o_timer_pin_zero.level);
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus request not answered after one cycle");
	a_rd_upper: assert property (p_rd_upper)
		else $error("read data upper bits not zero");
	a_on_init: assert property (p_on_init)
		else $error("pin not at initial level after timer start");
	a_timer_undriven: assert property (p_timer_undriven)
		else $error("pin driven in timer mode");
	a_cmp_driven: assert property (p_cmp_driven)
		else $error("pin not driven in compare mode");
	a_no_pflag: assert property (p_no_pflag)
		else $error("p flag raised while clearing on match a");
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("a flag fell without a clear write");
	a_off_quiet: assert property (p_off_quiet)
		else $error("match flag raised while timer off");
	a_same_level: assert property (p_same_level)
		else $error("pin moved when requested level equals initial");
endmodule
bind std_timer std_timer_asserts u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_timer_pin_zero(o_timer_pin_zero), .o_match_a_flag(o_match_a_flag),
	.o_match_p_flag(o_match_p_flag));

/* test/std_timer_far.sv */
// far-side pins: external count pin and the two capture pins
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/10ps
module std_timer_far (
	input wire logic i_mclk,
	output logic o_external_count_pin,
	output logic o_timer_pin_zero,
	output logic o_timer_pin_one
);
	initial begin
		o_external_count_pin = 1'b0;
		o_timer_pin_zero = 1'b0;
		o_timer_pin_one = 1'b0;
	end
	// each level stands 4 clocks so a two-flop synchroniser cannot miss it
	task automatic pulse_count(input int k);
		repeat (k) begin
			o_external_count_pin <= 1'b1;
			repeat (4) @(posedge i_mclk);
			o_external_count_pin <= 1'b0;
			repeat (4) @(posedge i_mclk);
		end
	endtask
	// one rising and one falling edge on capture pin zero
	task automatic pulse_pin();
		o_timer_pin_zero <= 1'b1;
		repeat (4) @(posedge i_mclk);
		o_timer_pin_zero <= 1'b0;
		repeat (8) @(posedge i_mclk);
	endtask
endmodule

/* test/test_standard_16bit_timer_module.sv */
// self-checking bench for the standard timer over avalon-mm
// assumes the far-side model and bound checker are compiled alongside
`timescale 1ns/10ps
module test_standard_16bit_timer_module;
	import std_timer_pkg::*;
	logic i_mclk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [4:0] adr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = '0;
	logic [3:0] be = 4'h1;
	logic tick = 1'b0;
	logic ext, pz, po, wreq, fa, fp, e;
	logic [31:0] rdat, v;
	logic [7:0] c;
	pin_out_t pin0, pin1;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	int n, k;
	always #5 i_mclk = ~i_mclk;
	// fh and time base pulse every other clock so the dividers finish quickly
	always @(posedge i_mclk) tick <= ~tick;
	std_timer uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
		.i_fh_tick(tick), .i_time_base_clock(tick), .i_external_count_pin(ext),
		.i_timer_pin_zero(pz), .i_timer_pin_one(po), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq), .o_timer_pin_zero(pin0), .o_timer_pin_one(pin1),
		.o_match_a_flag(fa), .o_match_p_flag(fp));
	std_timer_far far (.i_mclk(i_mclk), .o_external_count_pin(ext), .o_timer_pin_zero(pz),
		.o_timer_pin_one(po));
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus access held until waitrequest is sampled low; idle edge after it
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
		adr <= a;
		wdat <= {24'h000000, d};
		rd <= !w;
		wr <= w;
		@(posedge i_mclk);
		while (wreq !== 1'b0) @(posedge i_mclk);
		v = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic rd_cnt();
		xfer(0, ADDR_CNT_LO, 8'h00);
		n = int'(v[7:0]);
		xfer(0, ADDR_CNT_HI, 8'h00);
		n += 256 * int'(v[7:0]);
	endtask
	initial begin
		int sx [8] = '{32, 130, 4, 1, 65, 0, 5, 5};
		logic [7:0] pc [6] = '{8'ha8, 8'haa, 8'ha8, 8'h98, 8'h88, 8'h9c};
		logic [7:0] ph [6] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00};
		int pw [6] = '{256, 576, 256, 16, 16, 16};
		int pe [6] = '{64, 256, 256, 16, 0, 0};
		repeat (5) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		@(posedge i_mclk);
		for (int a = 0; a < 8; a++) begin
			xfer(0, 5'(a * 4), 8'h00);
			chk("reset value", v, 32'h0);
		end
		// counter bytes, a disabled lane and an unaligned address take no write
		xfer(1, ADDR_CMPA_LO, 8'h5a);
		xfer(1, ADDR_CNT_LO, 8'hff);
		xfer(1, 5'h02, 8'h33);
		be <= 4'h0;
		xfer(1, ADDR_PERIOD, 8'h77);
		be <= 4'h1;
		xfer(0, ADDR_CMPA_LO, 8'h00);
		chk("a low", v, 32'h5a);
		xfer(0, ADDR_CNT_LO, 8'h00);
		chk("count ro", v, 32'h0);
		xfer(0, ADDR_PERIOD, 8'h00);
		chk("period", v, 32'h0);
		xfer(0, 5'h02, 8'h00);
		chk("unmapped", v, 32'h0);
		// every clock source: on, run, off, then read the retained count
		xfer(1, ADDR_CTRL1, 8'hc0);
		for (int s = 0; s < 8; s++) begin
			xfer(1, ADDR_CTRL0, {1'b0, 3'(s), 4'h8});
			if (s > 5) far.pulse_count(5);
			else repeat (128) @(posedge i_mclk);
			xfer(1, ADDR_CTRL0, {1'b0, 3'(s), 4'h0});
			rd_cnt();
			chk("count", 32'(n >= sx[s] - 2 && n <= sx[s] + 2), 32'h1);
		end
		xfer(1, ADDR_CTRL0, 8'h18);
		repeat (20) @(posedge i_mclk);
		xfer(1, ADDR_CTRL0, 8'h98);
		rd_cnt();
		k = n;
		repeat (30) @(posedge i_mclk);
		rd_cnt();
		chk("paused", n, k);
		xfer(1, ADDR_CTRL0, 8'h18);
		repeat (30) @(posedge i_mclk);
		rd_cnt();
		chk("resumed", 32'(n >= k + 30), 32'h1);
		// compare output: every function with both initial levels and polarities
		xfer(1, ADDR_CMPA_LO, 8'h40);
		for (int i = 0; i < 8; i++) begin
			c = {2'b00, 2'(i), i[2], i[2] ^ i[0], 2'b01};
			xfer(1, ADDR_CTRL0, 8'h10);
			xfer(1, ADDR_CTRL1, c);
			xfer(1, ADDR_FLAGS, 8'h03);
			xfer(1, ADDR_CTRL0, 8'h18);
			repeat (2) @(posedge i_mclk);
			chk("start level", pin0.level, c[3] ^ c[2]);
			repeat (100) @(posedge i_mclk);
			e = (c[5:4] == 2'd0) ? c[3] : (c[5:4] == 2'd1) ? 1'b0 : (c[5:4] == 2'd2) ? 1'b1 : ~c[3];
			chk("match level", {pin1.level, pin0.level}, {2{e ^ c[2]}});
			chk("flag a", fa, 1'b1);
		end
		// p matches the top byte only: period 256 clocks for a value of 1
		xfer(1, ADDR_CTRL0, 8'h10);
		xfer(1, ADDR_CTRL1, 8'hc0);
		xfer(1, ADDR_PERIOD, 8'h01);
		xfer(1, ADDR_CMPA_HI, 8'hff);
		xfer(1, ADDR_FLAGS, 8'h03);
		xfer(1, ADDR_CTRL0, 8'h18);
		repeat (240) @(posedge i_mclk);
		xfer(0, ADDR_FLAGS, 8'h00);
		chk("no p yet", v, 32'h0);
		repeat (40) @(posedge i_mclk);
		xfer(0, ADDR_FLAGS, 8'h00);
		chk("p only", v, 32'h2);
		xfer(0, ADDR_CNT_HI, 8'h00);
		chk("p clears", v, 32'h0);
		xfer(1, ADDR_CTRL0, 8'h10);
		xfer(1, ADDR_CTRL1, 8'hc1);
		xfer(1, ADDR_CMPA_HI, 8'h00);
		xfer(1, ADDR_FLAGS, 8'h03);
		xfer(1, ADDR_CTRL0, 8'h18);
		repeat (300) @(posedge i_mclk);
		xfer(0, ADDR_FLAGS, 8'h00);
		chk("a only", v, 32'h1);
		// pwm: duty, role swap, full duty, forced levels with inversion
		for (int j = 0; j < 6; j++) begin
			xfer(1, ADDR_CTRL0, 8'h10);
			xfer(1, ADDR_CTRL1, pc[j]);
			xfer(1, ADDR_CMPA_HI, ph[j]);
			xfer(1, ADDR_CTRL0, 8'h18);
			repeat (600) @(posedge i_mclk);
			n = 0;
			repeat (pw[j]) begin
				@(posedge i_mclk);
				n += int'(pin0.level === 1'b1);
			end
			chk("pwm high", n, pe[j]);
		end
		// single pulse: active from the on-bit rise until match a at 64 ticks
		xfer(1, ADDR_CTRL0, 8'h10);
		xfer(1, ADDR_CTRL1, 8'hb8);
		xfer(1, ADDR_CMPA_HI, 8'h00);
		xfer(1, ADDR_CTRL0, 8'h18);
		repeat (2) @(posedge i_mclk);
		chk("pulse lead", pin0.level, 1'b1);
		repeat (100) @(posedge i_mclk);
		chk("pulse trail", pin0.level, 1'b0);
		// capture on every edge selection; disabled must not capture
		for (int f = 0; f < 4; f++) begin
			xfer(1, ADDR_CTRL0, 8'h10);
			xfer(1, ADDR_CTRL1, {2'b01, 2'(f), 4'h0});
			xfer(1, ADDR_FLAGS, 8'h03);
			xfer(1, ADDR_CTRL0, 8'h18);
			far.pulse_pin();
			xfer(0, ADDR_FLAGS, 8'h00);
			chk("capture flag", v[0], f != 3);
		end
		xfer(0, ADDR_CMPA_HI, 8'h00);
		chk("captured a", v, 32'h0);
		// last capture is the falling edge: six ticks after the on-bit rise clear
		xfer(0, ADDR_CMPA_LO, 8'h00);
		chk("captured a lo", v, 32'h06);
		end_of_test();
	end
endmodule
